// File: core/ledi2c_pkg.sv
// Purpose: Shared constants for the LED driver two-wire slave port.
// Assumes: Byte-wide registers at byte offsets 0x00 to 0x1F.
// Notes: Reset values of unnamed offsets are zero.
package ledi2c_pkg;

   // Own 7-bit slave address with the address-select pin grounded.
   localparam logic [6:0] OWN_ADDR = 7'h40;

   // Size of the register file and offset of its last register.
   localparam int REG_COUNT = 32;
   localparam logic [7:0] REG_LAST = 8'h1F;

   // Register offsets; in word pairs the high byte is at the even offset.
   localparam logic [7:0] OFS_LED_CHANNEL_ENABLE_WORD = 8'h00;
   localparam logic [7:0] OFS_PWM_PERIOD_WORD = 8'h02;
   localparam logic [7:0] OFS_CHANNEL1_ON_TIME_WORD = 8'h10;
   localparam logic [7:0] OFS_CHANNEL2_ON_TIME_WORD = 8'h12;
   localparam logic [7:0] OFS_CHANNEL8_ON_TIME_WORD = 8'h1E;
   localparam logic [7:0] OFS_OVP_THRESHOLD = 8'h04;
   localparam logic [7:0] OFS_FAULT_MODE = 8'h06;

   // Reset values of the registers that are not zero after reset.
   localparam logic [7:0] RST_ENABLE_HI = 8'h03;
   localparam logic [7:0] RST_ENABLE_LO = 8'hFF;
   localparam logic [7:0] RST_PERIOD_HI = 8'h0F;
   localparam logic [7:0] RST_PERIOD_LO = 8'hFF;
   localparam logic [7:0] RST_OVP = 8'h1C;
   localparam logic [7:0] RST_FAULT_HI = 8'h0A;
   localparam logic [7:0] RST_FAULT_LO = 8'hBE;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // Bit count of one byte on the wire, last index of the count.
   localparam logic [2:0] BIT_LAST = 3'h7;

   // Width of one buffered write: register offset and data byte.
   localparam int WR_WIDTH = 16;

   // Transfer sequence states, one-hot.
   typedef enum logic [5:0] {
      LEDI2C_IDLE = 6'h01,
      LEDI2C_ADDR = 6'h02,
      LEDI2C_RX = 6'h04,
      LEDI2C_ACK = 6'h08,
      LEDI2C_TX = 6'h10,
      LEDI2C_RACK = 6'h20
   } ledi2c_state_t;

endpackage

// File: core/ledi2c_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-high reset.
// Notes: Full and empty are exact; a stalled drain fills it.
`timescale 1ns/1ps
module ledi2c_buf2 #(
   parameter int DW = 16
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [DW-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [DW-1:0] out_data
);

   // Storage for the two entries.
   logic [DW-1:0] mem_r [0:1];
   // Write and read slot pointers.
   logic wp_r;
   logic rp_r;
   // Number of entries held, zero to two.
   logic [1:0] cnt_r;
   // Handshake strobes of both sides.
   logic push;
   logic pop;

   // The buffer accepts while a slot is free and offers while one is held.
   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = mem_r[rp_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Slot storage and pointers move on each accepted handshake.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         wp_r <= 1'b0;
         rp_r <= 1'b0;
      end else begin
         if (push) begin
            mem_r[wp_r] <= in_data;
            wp_r <= ~wp_r;
         end
         if (pop) begin
            rp_r <= ~rp_r;
         end
      end
   end

   // The fill count rises on a push, falls on a pop, holds on both.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= 2'h0;
      end else if (push & ~pop) begin
         cnt_r <= cnt_r + 2'h1;
      end else if (pop & ~push) begin
         cnt_r <= cnt_r - 2'h1;
      end
   end

endmodule

// File: core/ledi2c_slave.sv
// Purpose: Two-wire slave port holding the LED driver register file.
// Assumes: The master makes SCL and obeys the bus timing.
// Notes: SDA is open drain, driven low only while sda_oe is high.
// Behaviour
// - SDA falling with SCL high starts.
// - SDA rising with SCL high stops.
// - First byte: 7-bit address, direction bit.
// - Eight bits, MSB first, then acknowledge.
// - Start or stop resets transfer sequence.
// - Acknowledge own address in ninth clock.
// - Acknowledge every written byte; a data byte is not acknowledged while the write buffer is full.
// - Write: address, register select, data bytes.
// - Further written bytes go to next register.
// - Read: select, repeated start, read address.
// - Slave never drives SCL.
// - Keep sending while master acknowledges.
// - Any register readable, singly or burst.
// - No minimum SCL rate, wait forever.
// - Partial byte discarded on start or stop.
// - SCL input only, SDA open drain.
// - Responds to address 100 0000.
`timescale 1ns/1ps
module ledi2c_slave
   import ledi2c_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic wr_hold,
   output logic [15:0] led_channel_enable_word,
   output logic [15:0] pwm_period_word,
   output logic [127:0] on_time_words
);

   // Two-stage synchronisers and a third stage for edge detection.
   logic scl_s1_r;
   logic scl_s2_r;
   logic scl_s3_r;
   logic sda_s1_r;
   logic sda_s2_r;
   logic sda_s3_r;
   // Bus events decoded from the synchronised lines.
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   // Transfer sequence state and its shift path.
   ledi2c_state_t state_r;
   logic [7:0] shift_r;
   logic [2:0] cnt_r;
   logic done_r;
   logic rd_r;
   logic ptr_phase_r;
   logic [7:0] ptr_r;
   // Drive-low request of the SDA pin.
   logic oe_r;
   // Write request towards the buffer.
   logic push_r;
   logic [WR_WIDTH-1:0] push_data_r;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [WR_WIDTH-1:0] buf_out_data;
   // Register file and the shadow of a pending high byte.
   logic [7:0] mem_r [0:REG_COUNT-1];
   logic [7:0] hi_r;
   logic [7:0] hi_addr_r;
   logic hi_valid_r;
   // Write being drained into the register file.
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   // Byte at the pointer, loaded when a read byte starts.
   logic [7:0] rd_next;

   // True for the even offset that opens a word pair.
   function automatic logic pair_hi(input logic [7:0] a);
      logic hit;
      hit = (a == OFS_LED_CHANNEL_ENABLE_WORD) ||
            (a == OFS_PWM_PERIOD_WORD) ||
            ((a >= OFS_CHANNEL1_ON_TIME_WORD) &&
             (a <= OFS_CHANNEL8_ON_TIME_WORD) && !a[0]);
      return hit;
   endfunction

   // Reset value of the register at a given offset.
   function automatic logic [7:0] rst_val(input logic [7:0] a);
      logic [7:0] v;
      case (a)
         OFS_LED_CHANNEL_ENABLE_WORD: v = RST_ENABLE_HI;
         OFS_LED_CHANNEL_ENABLE_WORD + 8'h01: v = RST_ENABLE_LO;
         OFS_PWM_PERIOD_WORD: v = RST_PERIOD_HI;
         OFS_PWM_PERIOD_WORD + 8'h01: v = RST_PERIOD_LO;
         OFS_OVP_THRESHOLD: v = RST_OVP;
         OFS_FAULT_MODE: v = RST_FAULT_HI;
         OFS_FAULT_MODE + 8'h01: v = RST_FAULT_LO;
         default: v = RST_ZERO;
      endcase
      return v;
   endfunction

   // Byte returned for a read; offsets past the file read as zero.
   function automatic logic [7:0] rd_byte(input logic [7:0] a,
                                          input logic [7:0] m);
      return (a <= REG_LAST) ? m : RST_ZERO;
   endfunction

   // Both pins are sampled twice before any logic looks at them.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_s3_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_s3_r <= 1'b1;
      end else begin
         scl_s1_r <= scl_i;
         scl_s2_r <= scl_s1_r;
         scl_s3_r <= scl_s2_r;
         sda_s1_r <= sda_i;
         sda_s2_r <= sda_s1_r;
         sda_s3_r <= sda_s2_r;
      end
   end

   // Clock edges, and SDA edges while SCL stays high.
   assign scl_rise = scl_s2_r & ~scl_s3_r;
   assign scl_fall = ~scl_s2_r & scl_s3_r;
   assign bus_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
   assign bus_stop = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

   // Byte at the pointer, or zero past the end of the file.
   assign rd_next = rd_byte(ptr_r, mem_r[ptr_r[4:0]]);

   // SDA only ever pulls low; SCL has no output at all.
   assign sda_o = 1'b0;
   assign sda_oe = oe_r;

   // Transfer sequence: bits are taken on SCL rising and SDA is
   // changed on SCL falling, so the master's setup window is kept.
   // Nothing here times out, so a paused master is simply waited for.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= LEDI2C_IDLE;
         shift_r <= 8'h00;
         cnt_r <= 3'h0;
         done_r <= 1'b0;
         rd_r <= 1'b0;
         ptr_phase_r <= 1'b0;
         oe_r <= 1'b0;
         push_r <= 1'b0;
         push_data_r <= '0;
         ptr_r <= 8'h00;
      end else begin
         push_r <= 1'b0;
         if (bus_start) begin
            // A start, first or repeated, drops any partial byte.
            state_r <= LEDI2C_ADDR;
            cnt_r <= 3'h0;
            done_r <= 1'b0;
            oe_r <= 1'b0;
         end else if (bus_stop) begin
            // A stop ends the transfer and releases the line.
            state_r <= LEDI2C_IDLE;
            cnt_r <= 3'h0;
            done_r <= 1'b0;
            oe_r <= 1'b0;
         end else begin
            case (state_r)
               LEDI2C_IDLE: begin
                  // Nothing happens until a start is seen.
                  oe_r <= 1'b0;
               end
               LEDI2C_ADDR: begin
                  // Address byte, MSB first, direction bit last.
                  if (scl_rise && !done_r) begin
                     shift_r <= {shift_r[6:0], sda_s2_r};
                     cnt_r <= cnt_r + 3'h1;
                     done_r <= (cnt_r == BIT_LAST);
                  end else if (scl_fall && done_r) begin
                     done_r <= 1'b0;
                     cnt_r <= 3'h0;
                     if (shift_r[7:1] == OWN_ADDR) begin
                        // Own address: pull low for the ninth clock.
                        oe_r <= 1'b1;
                        rd_r <= shift_r[0];
                        ptr_phase_r <= ~shift_r[0];
                        state_r <= LEDI2C_ACK;
                     end else begin
                        // Another slave is addressed; stay released.
                        state_r <= LEDI2C_IDLE;
                     end
                  end
               end
               LEDI2C_RX: begin
                  // Register select byte or data byte from the master.
                  if (scl_rise && !done_r) begin
                     shift_r <= {shift_r[6:0], sda_s2_r};
                     cnt_r <= cnt_r + 3'h1;
                     done_r <= (cnt_r == BIT_LAST);
                  end else if (scl_fall && done_r) begin
                     done_r <= 1'b0;
                     cnt_r <= 3'h0;
                     if (ptr_phase_r) begin
                        // First byte after a write address selects.
                        ptr_r <= shift_r;
                        ptr_phase_r <= 1'b0;
                        oe_r <= 1'b1;
                        state_r <= LEDI2C_ACK;
                     end else if (buf_in_ready) begin
                        // Whole byte queued, then the pointer steps.
                        push_r <= 1'b1;
                        push_data_r <= {ptr_r, shift_r};
                        ptr_r <= ptr_r + 8'h01;
                        oe_r <= 1'b1;
                        state_r <= LEDI2C_ACK;
                     end else begin
                        // No room: leave SDA high so the master sees
                        // a refusal and the byte is not lost silently.
                        state_r <= LEDI2C_IDLE;
                     end
                  end
               end
               LEDI2C_ACK: begin
                  // The ninth clock ends on its falling edge.
                  if (scl_fall) begin
                     if (rd_r) begin
                        // Read: first data bit goes out at once.
                        shift_r <= rd_next;
                        oe_r <= ~rd_next[7];
                        ptr_r <= ptr_r + 8'h01;
                        cnt_r <= 3'h0;
                        state_r <= LEDI2C_TX;
                     end else begin
                        oe_r <= 1'b0;
                        state_r <= LEDI2C_RX;
                     end
                  end
               end
               LEDI2C_TX: begin
                  // Shift the read byte out, one bit per falling edge.
                  if (scl_fall) begin
                     if (cnt_r == BIT_LAST) begin
                        oe_r <= 1'b0;
                        state_r <= LEDI2C_RACK;
                     end else begin
                        oe_r <= ~shift_r[6];
                        shift_r <= {shift_r[6:0], 1'b0};
                        cnt_r <= cnt_r + 3'h1;
                     end
                  end
               end
               LEDI2C_RACK: begin
                  // Master acknowledge decides whether to go on.
                  if (scl_rise && !done_r) begin
                     if (sda_s2_r) begin
                        state_r <= LEDI2C_IDLE;
                     end else begin
                        done_r <= 1'b1;
                     end
                  end else if (scl_fall && done_r) begin
                     // Acknowledged: next higher register follows.
                     done_r <= 1'b0;
                     shift_r <= rd_next;
                     oe_r <= ~rd_next[7];
                     ptr_r <= ptr_r + 8'h01;
                     cnt_r <= 3'h0;
                     state_r <= LEDI2C_TX;
                  end
               end
               default: begin
                  state_r <= LEDI2C_IDLE;
                  oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Completed write bytes wait here; wr_hold stalls the drain.
   ledi2c_buf2 #(
      .DW(WR_WIDTH)
   ) u_buf (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .in_valid(push_r),
      .in_ready(buf_in_ready),
      .in_data(push_data_r),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   assign buf_out_ready = ~wr_hold;
   assign wr_addr = buf_out_data[15:8];
   assign wr_data = buf_out_data[7:0];

   // Register file update: word pairs go through the shadow byte so
   // the logic behind never sees half of a new word.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < REG_COUNT; i++) begin
            mem_r[i] <= rst_val(8'(i));
         end
         hi_r <= 8'h00;
         hi_addr_r <= 8'h00;
         hi_valid_r <= 1'b0;
      end else if (buf_out_valid && buf_out_ready &&
                   (wr_addr <= REG_LAST)) begin
         if (pair_hi(wr_addr)) begin
            // High byte of a pair is held back.
            hi_r <= wr_data;
            hi_addr_r <= wr_addr;
            hi_valid_r <= 1'b1;
         end else if (pair_hi(wr_addr - 8'h01)) begin
            // Low byte commits the held high byte with it.
            if (hi_valid_r && (hi_addr_r == wr_addr - 8'h01)) begin
               mem_r[hi_addr_r[4:0]] <= hi_r;
               mem_r[wr_addr[4:0]] <= wr_data;
            end
            hi_valid_r <= 1'b0;
         end else begin
            // Plain byte registers take the data at once.
            mem_r[wr_addr[4:0]] <= wr_data;
         end
      end
   end

   // Word outputs towards the channel logic, straight from flops.
   assign led_channel_enable_word = {mem_r[0], mem_r[1]};
   assign pwm_period_word = {mem_r[2], mem_r[3]};

   // Eight on-time words, channel 1 in the low bits.
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_on
         assign on_time_words[g*16 +: 16] =
            {mem_r[16 + 2*g], mem_r[17 + 2*g]};
      end
   endgenerate

endmodule

// File: bench/ledi2c_slave_assertions.sv
// Purpose: Bus-level checks on the two-wire slave port.
// Assumes: Sees only the slave's ports; the bench resolves SDA.
// Notes: Helper logic counts SCL rises from each start.
`timescale 1ns/1ps
module ledi2c_slave_assertions
   import ledi2c_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic wr_hold,
   input wire logic [15:0] led_channel_enable_word,
   input wire logic [15:0] pwm_period_word,
   input wire logic [127:0] on_time_words
);
   logic scl_q, sda_q, frst, sel, wrt, done, rise, stt, nine;
   logic [3:0] cnt; // SCL rises within the current byte.
   logic [7:0] sh; // Bits seen on the wire, newest at bit 0.
   assign rise = scl_i && !scl_q;
   assign stt = scl_q && scl_i && sda_q && !sda_i;
   assign nine = rise && cnt == 4'h8;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   // Tracks byte count, addressing and direction of each transfer.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         cnt <= 4'h0;
         frst <= 1'b1;
         sel <= 1'b0;
         wrt <= 1'b0;
         done <= 1'b0;
         sh <= 8'h00;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
         if (stt) begin
            cnt <= 4'h0;
            frst <= 1'b1;
            done <= 1'b0;
         end else if (rise) begin
            sh <= {sh[6:0], sda_i};
            cnt <= nine ? 4'h0 : cnt + 4'h1;
            if (nine && frst) begin
               sel <= sh[7:1] == OWN_ADDR;
               wrt <= !sh[0];
            end
            if (nine) begin
               frst <= 1'b0;
            end
            if (nine && !frst && sel && !wrt && sda_i) begin
               done <= 1'b1;
            end
         end
      end
   end
   a_sda_low: assert property (sda_o == 1'b0)
      else $error("sda_o not low");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("sda_oe moved with SCL high");
   a_addr_quiet: assert property (frst && cnt < 4'h8 |-> !sda_oe)
      else $error("SDA driven during address");
   a_addr_ack: assert property (nine && frst |->
      sda_oe == (sh[7:1] == OWN_ADDR))
      else $error("address acknowledge wrong");
   a_wr_ack: assert property (nine && !frst && sel && wrt &&
      !wr_hold |-> sda_oe)
      else $error("written byte not acknowledged");
   a_no_ack_wrong: assert property (nine && !frst && !sel |-> !sda_oe)
      else $error("foreign transfer acknowledged");
   a_rd_release: assert property (nine && !frst && sel && !wrt |->
      !sda_oe)
      else $error("SDA held in read acknowledge");
   a_nack_quiet: assert property (done |-> !sda_oe)
      else $error("SDA driven after read end");
   a_hold_blocks: assert property ($changed({led_channel_enable_word,
      pwm_period_word, on_time_words}) |-> !$past(wr_hold))
      else $error("word changed while held");
   c_addr: cover property (nine && frst && sda_oe);
   c_wr: cover property (nine && !frst && wrt && sda_oe);
   c_nack: cover property (done);
   c_full: cover property (nine && !frst && wr_hold && !sda_oe);
endmodule
bind ledi2c_slave ledi2c_slave_assertions u_chk (.core_clk(core_clk),
   .sys_rst(sys_rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe(sda_oe), .wr_hold(wr_hold),
   .led_channel_enable_word(led_channel_enable_word),
   .pwm_period_word(pwm_period_word), .on_time_words(on_time_words));

// File: bench/ledi2c_master.sv
// Purpose: Behavioural bus master facing the slave port.
// Assumes: SDA has a pull-up; the bench resolves the wire.
// Notes: Lines change 1 ns after a clock edge; SCL idles high.
`timescale 1ns/1ps
module ledi2c_master (
   input wire logic core_clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_drv,
   output logic got_v,
   output logic [7:0] got
);
   int pl = 8; // Clock cycles in each bus phase.
   // Idle bus: SCL stands high, SDA released to the pull-up.
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      got_v = 1'b0;
      got = 8'h00;
   end
   // Waits one bus phase and steps off the edge.
   task ph;
      repeat (pl) @(posedge core_clk);
      #1;
   endtask
   // Start or repeated start: SDA falls while SCL is high.
   task start;
      sda_drv = 1'b1;
      ph;
      scl = 1'b1;
      ph;
      sda_drv = 1'b0;
      ph;
      scl = 1'b0;
      ph;
   endtask
   // Stop: SDA rises while SCL is high.
   task stop;
      sda_drv = 1'b0;
      ph;
      scl = 1'b1;
      ph;
      sda_drv = 1'b1;
      ph;
   endtask
   // One bit: SDA set in the low phase, sampled in the high phase.
   task bitx(input logic b, output logic r);
      sda_drv = b;
      ph;
      scl = 1'b1;
      ph;
      r = sda_in;
      scl = 1'b0;
      ph;
   endtask
   // Sends a byte MSB first, then releases SDA for the answer.
   task wbyte(input logic [7:0] d, output logic a);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, a);
   endtask
   // Takes a byte, then acknowledges it unless it is the last.
   task rbyte(input logic last);
      logic r;
      logic [7:0] v;
      for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
      bitx(last, r);
      got = v;
      got_v = 1'b1;
      @(posedge core_clk);
      #1;
      got_v = 1'b0;
   endtask
endmodule

// File: bench/ledi2c_slave_bench.sv
// Purpose: Self-checking bench for the two-wire slave port.
// Assumes: Master model drives the bus; SDA pulled up.
// Notes: Read bytes are checked against a queue of expectations.
`timescale 1ns/1ps
module ledi2c_slave_bench
   import ledi2c_pkg::*;
;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic wr_hold = 1'b0;
   logic scl, sda_drv, got_v, sda_o, sda_oe, sda_i, a;
   logic [7:0] got, shp, shd, d1, d2;
   logic [7:0] mem [0:31]; // Expected register image.
   logic [7:0] q [$]; // Expected read bytes, oldest first.
   logic [15:0] en_w, per_w;
   logic [127:0] on_w;
   logic [31:0] rs = 32'h00015A38;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   assign sda_i = sda_drv & ~sda_oe; // Wired-AND with pull-up.
   ledi2c_master m (.core_clk(core_clk), .sda_in(sda_i), .scl(scl),
      .sda_drv(sda_drv), .got_v(got_v), .got(got));
   ledi2c_slave dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
      .wr_hold(wr_hold), .led_channel_enable_word(en_w),
      .pwm_period_word(per_w), .on_time_words(on_w));
   initial forever #5 core_clk = ~core_clk;
   function automatic logic [7:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs[7:0];
   endfunction
   task fail(input string s);
      error_cnt++;
      $display("mismatch at %0t: %s", $time, s);
   endtask
   task chk_ack(input logic g, input logic e);
      checked++;
      if (g !== e) fail("acknowledge level");
   endtask
   task chk_byte(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) fail("read byte");
   endtask
   task chk_word(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) fail("register word");
   endtask
   // Word pairs commit only when the odd byte meets its even half.
   task apply(input logic [7:0] p, input logic [7:0] d);
      if (p > REG_LAST) return;
      if (p < 8'h04 || p >= OFS_CHANNEL1_ON_TIME_WORD) begin
         if (!p[0]) begin
            shp = p;
            shd = d;
         end else begin
            // Any odd byte of a pair empties the shadow.
            if (shp == p - 8'h01) begin
               mem[shp] = shd;
               mem[p] = d;
            end
            shp = 8'hFF;
         end
      end else mem[p] = d;
   endtask
   task chk_all;
      chk_word(en_w, {mem[0], mem[1]});
      chk_word(per_w, {mem[2], mem[3]});
      for (int n = 0; n < 8; n++) begin
         chk_word(on_w[n*16 +: 16], {mem[16+2*n], mem[17+2*n]});
      end
   endtask
   task addr(input logic r, input logic e);
      m.start;
      m.wbyte({OWN_ADDR, r}, a);
      chk_ack(a, e);
   endtask
   task put(input logic [7:0] d, input logic e);
      m.wbyte(d, a);
      chk_ack(a, e);
   endtask
   // Reads n bytes from offset p after a repeated start.
   task rd(input logic [7:0] p, input int n);
      logic [7:0] o;
      addr(1'b0, 1'b0);
      put(p, 1'b0);
      addr(1'b1, 1'b0);
      for (int i = 0; i < n; i++) begin
         o = p + 8'(i);
         q.push_back(o > REG_LAST ? RST_ZERO : mem[o]);
         m.rbyte(i == n - 1);
      end
      m.stop;
   endtask
   // Writes n random bytes from offset p in one burst.
   task wr(input logic [7:0] p, input int n);
      logic [7:0] d;
      addr(1'b0, 1'b0);
      put(p, 1'b0);
      for (int i = 0; i < n; i++) begin
         d = rnd();
         put(d, 1'b0);
         apply(p + 8'(i), d);
      end
      m.stop;
   endtask
   task end_of_test;
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Each read byte takes the oldest expectation off the queue.
   always @(posedge core_clk) begin
      if (got_v === 1'b1) begin
         if (q.size() == 0) fail("unexpected byte");
         else chk_byte(got, q.pop_front());
      end
   end
   // Cuts a hung run short.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 90000) begin
         fail("timeout");
         end_of_test;
      end
   end
   initial begin
      for (int i = 0; i < 32; i++) mem[i] = RST_ZERO;
      mem[0] = RST_ENABLE_HI;
      mem[1] = RST_ENABLE_LO;
      mem[2] = RST_PERIOD_HI;
      mem[3] = RST_PERIOD_LO;
      mem[4] = RST_OVP;
      mem[6] = RST_FAULT_HI;
      mem[7] = RST_FAULT_LO;
      shp = 8'hFF;
      repeat (5) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      repeat (5) @(posedge core_clk);
      #1;
      chk_all;
      rd(8'h00, 8);
      $display("test reset done");
      wr(8'h00, 8);
      chk_all;
      rd(8'h00, 8);
      $display("test burst done");
      wr(8'h10, 1);
      chk_all;
      wr(8'h13, 1);
      chk_all;
      for (int n = 0; n < 8; n++) wr(8'h10 + 8'(2 * n), 2);
      chk_all;
      rd(8'h10, 16);
      $display("test pairs done");
      m.start;
      m.wbyte({OWN_ADDR ^ 7'h15, 1'b0}, a);
      chk_ack(a, 1'b1);
      put(8'h05, 1'b1);
      m.stop;
      chk_all;
      $display("test foreign done");
      m.pl = 300;
      wr(8'h05, 1);
      m.pl = 8;
      addr(1'b0, 1'b0);
      put(8'h05, 1'b0);
      for (int i = 0; i < 4; i++) m.bitx(1'b0, a);
      m.stop;
      addr(1'b0, 1'b0);
      put(8'h05, 1'b0);
      for (int i = 0; i < 5; i++) m.bitx(1'b0, a);
      addr(1'b0, 1'b0);
      m.stop;
      rd(8'h05, 1);
      wr(8'h20, 1);
      chk_all;
      rd(8'h1E, 4);
      $display("test abort done");
      wr_hold = 1'b1;
      d1 = rnd();
      d2 = rnd();
      addr(1'b0, 1'b0);
      put(8'h08, 1'b0);
      put(d1, 1'b0);
      put(d2, 1'b0);
      put(rnd(), 1'b1);
      m.stop;
      wr_hold = 1'b0;
      apply(8'h08, d1);
      apply(8'h09, d2);
      rd(8'h08, 2);
      $display("test hold done");
      end_of_test;
   end
endmodule
